/* File: core/scsi_dma_pkg.sv */
package scsi_dma_pkg;
  localparam int          DATA_W         = 8;
  localparam logic [2:0]  ADDR_DATA      = 3'h0;
  localparam logic [2:0]  ADDR_MODE      = 3'h1;
  localparam logic [2:0]  ADDR_STATUS    = 3'h2;
  localparam logic [2:0]  ADDR_CTRL      = 3'h3;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam int          MODE_DMA_BIT   = 0;
  localparam int          MODE_PCHK_BIT  = 1;
  localparam int          MODE_TGT_BIT   = 2;
  localparam int          MODE_ARB_BIT   = 3;
  localparam int          MODE_SEND_BIT  = 4;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;

  typedef enum logic [2:0] {
    XFER_IDLE = 3'b001,
    XFER_REQ  = 3'b010,
    XFER_ACK  = 3'b100
  } xfer_state_t;
endpackage

/* File: core/scsi_dma_if.sv */
`timescale 1ns/1ps
interface scsi_dma_if;
  logic [7:0] wr_data;
  logic       wr_en;
  logic [7:0] rd_data;
  logic       rd_en;
  modport host (output wr_data, output wr_en, output rd_en, input rd_data);
  modport port (input wr_data, input wr_en, input rd_en, output rd_data);
endinterface

/* File: core/scsi_data_latch.sv */
`timescale 1ns/1ps
module scsi_data_latch
  import scsi_dma_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  scsi_dma_if.port  lat
);
  logic [DATA_W-1:0] mem;
  logic [DATA_W-1:0] next_mem;
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] next_rd_q;

  always_comb begin
    next_mem  = lat.wr_en ? lat.wr_data : mem;
    next_rd_q = lat.rd_en ? mem : rd_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem  <= BYTE_RESET;
      rd_q <= BYTE_RESET;
    end else begin
      mem  <= next_mem;
      rd_q <= next_rd_q;
    end
  end

  assign lat.rd_data = rd_q;
endmodule

/* File: core/scsi_bus_dma_handshake.sv */
`timescale 1ns/1ps
// What this block does
// - dma_request rises when the data register is ready, only while DMA mode is enabled.
// - an active-low dma_acknowledge clears dma_request.
// - dma_acknowledge replaces bus_unit_select and routes the access to the data register.
// - read strobe with dma_acknowledge puts the input data register on the host bus.
// - odd parity is driven with every byte sent in send mode; received parity checking is optional.
// - parity is ignored during arbitration and never flagged then.
// - the target drives control/data, true meaning control, false meaning data.
// - the open-drain active-low busy line marks the bus in use, driven by either role.
// - the SCSI data bus is eight active-low open-drain lines, bit 0 least significant.
// - end_of_process_input during a DMA cycle ends requests after the current byte.
// - the host data bus is 8-bit active-high tri-state, bit 0 least significant.
module scsi_bus_dma_handshake
  import scsi_dma_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic       bus_unit_select_n_i,
  input  wire logic       dma_acknowledge_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       end_of_process_input_n_i,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe_o,
  output logic            dma_request_o,
  input  wire logic [7:0] scsi_data_n_i,
  output logic      [7:0] scsi_data_n_o,
  output logic      [7:0] scsi_data_oe_o,
  input  wire logic       scsi_parity_n_i,
  output logic            scsi_parity_n_o,
  output logic            scsi_parity_oe_o,
  input  wire logic       busy_n_i,
  output logic            busy_n_o,
  output logic            busy_oe_o,
  input  wire logic       control_data_i,
  output logic            control_data_o,
  output logic            control_data_oe_o,
  input  wire logic       data_strobe_i,
  output logic            parity_error_o,
  output logic            bus_in_use_o,
  output logic            control_phase_o
);
  scsi_dma_if lat ();

  xfer_state_t state;
  xfer_state_t next_state;
  logic [7:0]  mode;
  logic [7:0]  next_mode;
  logic [7:0]  ctrl_out;
  logic [7:0]  next_ctrl_out;
  logic [7:0]  out_byte;
  logic [7:0]  next_out_byte;
  logic        halted;
  logic        next_halted;
  logic        par_err;
  logic        next_par_err;
  logic        rd_prev;
  logic        rd_pend;
  logic        next_rd_pend;
  logic [7:0]  rd_mux;
  logic [7:0]  next_rd_mux;

  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~^b;
  endfunction

  // access decode: dma_acknowledge selects the data register alone
  logic dma_sel;
  logic reg_sel;
  logic acc_rd;
  logic acc_wr;
  assign dma_sel = ~dma_acknowledge_n_i;
  assign reg_sel = ~bus_unit_select_n_i & dma_acknowledge_n_i;
  assign acc_rd  = ~rd_n_i & (dma_sel | reg_sel);
  assign acc_wr  = ~wr_n_i & (dma_sel | reg_sel);

  logic data_acc;
  assign data_acc = dma_sel | (reg_sel & addr_i == ADDR_DATA);

  // receive path: latch SCSI byte on strobe while send mode is off; host data-register writes go to out_byte
  logic [7:0] rx_byte;
  assign rx_byte = ~scsi_data_n_i;
  always_comb begin
    lat.wr_en   = 1'b0;
    lat.wr_data = rx_byte;
    if (data_strobe_i && !mode[MODE_SEND_BIT]) begin
      lat.wr_en = 1'b1;
    end
    lat.rd_en = acc_rd & data_acc & ~rd_prev;
  end

  scsi_data_latch u_latch (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .lat       (lat.port)
  );

  always_comb begin
    next_mode     = mode;
    next_ctrl_out = ctrl_out;
    next_out_byte = out_byte;
    if (acc_wr && !data_acc && addr_i == ADDR_MODE) begin
      next_mode = host_data_i;
    end
    if (acc_wr && !data_acc && addr_i == ADDR_CTRL) begin
      next_ctrl_out = host_data_i;
    end
    if (acc_wr && data_acc) begin
      next_out_byte = host_data_i;
    end
  end

  // handshake
  always_comb begin
    next_state  = state;
    next_halted = halted;
    if (!mode[MODE_DMA_BIT]) begin
      next_state  = XFER_IDLE;
      next_halted = 1'b0;
    end else begin
      if (!end_of_process_input_n_i && state != XFER_IDLE) begin
        next_halted = 1'b1;
      end
      case (state)
        XFER_IDLE: begin
          if (!halted && (mode[MODE_SEND_BIT] || data_strobe_i)) begin
            next_state = XFER_REQ;
          end
        end
        XFER_REQ: begin
          if (dma_sel) begin
            next_state = XFER_ACK;
          end
        end
        XFER_ACK: begin
          if (!dma_sel) begin
            next_state = XFER_IDLE;
          end
        end
        default: next_state = XFER_IDLE;
      endcase
    end
  end

  // parity check
  always_comb begin
    next_par_err = par_err;
    if (acc_rd && !data_acc && addr_i == ADDR_STATUS && !rd_prev) begin
      next_par_err = 1'b0;
    end
    if (data_strobe_i && mode[MODE_PCHK_BIT] && !mode[MODE_ARB_BIT]
        && (~scsi_parity_n_i) != odd_par(rx_byte)) begin
      next_par_err = 1'b1;
    end
  end

  // host read mux
  always_comb begin
    next_rd_pend = acc_rd;
    case (addr_i)
      ADDR_MODE:   next_rd_mux = mode;
      ADDR_STATUS: next_rd_mux = {4'h0, par_err, ~busy_n_i, control_data_i, state == XFER_REQ};
      ADDR_CTRL:   next_rd_mux = ctrl_out;
      default:     next_rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state    <= XFER_IDLE;
      mode     <= MODE_RESET;
      ctrl_out <= BYTE_RESET;
      out_byte <= BYTE_RESET;
      halted   <= 1'b0;
      par_err  <= 1'b0;
      rd_prev  <= 1'b0;
      rd_pend  <= 1'b0;
      rd_mux   <= BYTE_RESET;
    end else begin
      state    <= next_state;
      mode     <= next_mode;
      ctrl_out <= next_ctrl_out;
      out_byte <= next_out_byte;
      halted   <= next_halted;
      par_err  <= next_par_err;
      rd_prev  <= acc_rd;
      rd_pend  <= next_rd_pend;
      rd_mux   <= next_rd_mux;
    end
  end

  // ctrl_out: bit0 busy, bit1 control/data; data read returns latched byte
  logic data_rd_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_rd_q         <= 1'b0;
      host_data_oe_o    <= 1'b0;
      host_data_o       <= BYTE_RESET;
      dma_request_o     <= 1'b0;
      scsi_data_n_o     <= BYTE_RESET;
      scsi_data_oe_o    <= BYTE_RESET;
      scsi_parity_n_o   <= 1'b0;
      scsi_parity_oe_o  <= 1'b0;
      busy_n_o          <= 1'b0;
      busy_oe_o         <= 1'b0;
      control_data_o    <= 1'b0;
      control_data_oe_o <= 1'b0;
      parity_error_o    <= 1'b0;
      bus_in_use_o      <= 1'b0;
      control_phase_o   <= 1'b0;
    end else begin
      data_rd_q         <= acc_rd & data_acc;
      host_data_oe_o    <= rd_pend & acc_rd;
      host_data_o       <= data_rd_q ? lat.rd_data : rd_mux;
      dma_request_o     <= next_state == XFER_REQ && mode[MODE_DMA_BIT];
      scsi_data_n_o     <= 8'h00;
      scsi_data_oe_o    <= mode[MODE_SEND_BIT] ? out_byte : 8'h00;
      scsi_parity_n_o   <= 1'b0;
      scsi_parity_oe_o  <= mode[MODE_SEND_BIT] & odd_par(out_byte);
      busy_n_o          <= 1'b0;
      busy_oe_o         <= ctrl_out[0];
      control_data_o    <= 1'b1;
      control_data_oe_o <= mode[MODE_TGT_BIT] & ctrl_out[1];
      parity_error_o    <= next_par_err;
      bus_in_use_o      <= ~busy_n_i;
      control_phase_o   <= control_data_i;
    end
  end
endmodule

/* File: tb/scsi_bus_dma_handshake_assertions.sv */
`timescale 1ns/1ps
module scsi_bus_dma_handshake_assertions (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       bus_unit_select_n_i,
  input wire logic       dma_acknowledge_n_i,
  input wire logic       rd_n_i,
  input wire logic       host_data_oe_o,
  input wire logic       dma_request_o,
  input wire logic [7:0] scsi_data_n_o,
  input wire logic [7:0] scsi_data_oe_o,
  input wire logic       scsi_parity_oe_o,
  input wire logic       busy_n_i,
  input wire logic       control_data_i,
  input wire logic       control_data_o,
  input wire logic       control_data_oe_o,
  input wire logic       bus_in_use_o,
  input wire logic       control_phase_o
);
  logic rd_sel;
  assign rd_sel = !rd_n_i && (!bus_unit_select_n_i || !dma_acknowledge_n_i);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_level_zero: assert property (scsi_data_n_o == 8'h00)
    else $error("scsi data level not zero");
  a_parity_odd: assert property (|scsi_data_oe_o |-> ^{scsi_data_oe_o, scsi_parity_oe_o})
    else $error("driven parity not odd");
  a_busy_follows: assert property (!$past(rst_i) |-> bus_in_use_o == !$past(busy_n_i))
    else $error("bus in use does not follow busy");
  a_phase_follows: assert property (!$past(rst_i) |-> control_phase_o == $past(control_data_i))
    else $error("control phase does not follow line");
  a_cd_true: assert property (control_data_oe_o |-> control_data_o)
    else $error("control line driven false");
  a_host_idle: assert property (host_data_oe_o |-> $past(rd_sel))
    else $error("host bus driven without read");
  a_read_answer: assert property (rd_sel [*4] |-> host_data_oe_o)
    else $error("read not answered");
  a_req_clear: assert property (dma_request_o && !dma_acknowledge_n_i |-> ##[1:2] !dma_request_o)
    else $error("request not cleared by acknowledge");
endmodule
bind scsi_bus_dma_handshake scsi_bus_dma_handshake_assertions scsi_bus_dma_handshake_assertions_i (.clk_sys_i,
  .rst_i, .bus_unit_select_n_i, .dma_acknowledge_n_i, .rd_n_i, .host_data_oe_o, .dma_request_o, .scsi_data_n_o,
  .scsi_data_oe_o, .scsi_parity_oe_o, .busy_n_i, .control_data_i, .control_data_o, .control_data_oe_o,
  .bus_in_use_o, .control_phase_o);

/* File: tb/scsi_far_end.sv */
`timescale 1ns/1ps
module scsi_far_end (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] dut_data_oe_i,
  input  wire logic       dut_parity_oe_i,
  input  wire logic       dut_busy_oe_i,
  input  wire logic       dut_cd_oe_i,
  input  wire logic       dut_cd_i,
  output logic      [7:0] data_n_o,
  output logic            parity_n_o,
  output logic            busy_n_o,
  output logic            cd_o,
  output logic            strobe_o
);
  logic [7:0] m_oe = 8'h00;
  logic       m_par = 1'b0;
  logic       m_stb = 1'b0;
  // terminated lines, released means high; released control/data reads false (0)
  assign data_n_o   = ~(dut_data_oe_i | m_oe);
  assign parity_n_o = ~(dut_parity_oe_i | m_par);
  assign busy_n_o   = ~dut_busy_oe_i;
  assign cd_o       = dut_cd_oe_i ? dut_cd_i : 1'b0;
  assign strobe_o   = m_stb;
  task automatic send(input logic [7:0] b, input logic bad);
    @(posedge clk_sys_i);
    m_oe <= b;
    m_par <= ~^b ^ bad;
    @(posedge clk_sys_i);
    m_stb <= 1'b1;
    @(posedge clk_sys_i);
    m_stb <= 1'b0;
    @(posedge clk_sys_i);
    m_oe <= 8'h00;
    m_par <= 1'b0;
  endtask
endmodule

/* File: tb/scsi_bus_dma_handshake_tb.sv */
`timescale 1ns/1ps
module scsi_bus_dma_handshake_tb import scsi_dma_pkg::*; ;
  localparam logic [7:0] M_DMA = 8'h01 << MODE_DMA_BIT;
  localparam logic [7:0] M_PCK = 8'h01 << MODE_PCHK_BIT;
  localparam logic [7:0] M_ARB = 8'h01 << MODE_ARB_BIT;
  localparam logic [7:0] M_SND = 8'h01 << MODE_SEND_BIT;
  logic        clk_sys_i, rst_i, bus_unit_select_n_i, dma_acknowledge_n_i, rd_n_i, wr_n_i;
  logic        end_of_process_input_n_i, scsi_parity_n_i, busy_n_i, control_data_i, data_strobe_i;
  logic        host_data_oe_o, dma_request_o, scsi_parity_n_o, scsi_parity_oe_o, busy_n_o, busy_oe_o;
  logic        control_data_o, control_data_oe_o, parity_error_o, bus_in_use_o, control_phase_o;
  logic [2:0]  addr_i;
  logic [7:0]  host_data_i, host_data_o, scsi_data_n_i, scsi_data_n_o, scsi_data_oe_o, q, b;
  logic [31:0] seed;
  int          err_total = 0;
  int          n_compared = 0;
  scsi_bus_dma_handshake scsi_bus_dma_handshake_i (.clk_sys_i, .rst_i, .addr_i, .bus_unit_select_n_i,
    .dma_acknowledge_n_i, .rd_n_i, .wr_n_i, .end_of_process_input_n_i, .host_data_i, .host_data_o, .host_data_oe_o,
    .dma_request_o, .scsi_data_n_i, .scsi_data_n_o, .scsi_data_oe_o, .scsi_parity_n_i, .scsi_parity_n_o,
    .scsi_parity_oe_o, .busy_n_i, .busy_n_o, .busy_oe_o, .control_data_i, .control_data_o, .control_data_oe_o,
    .data_strobe_i, .parity_error_o, .bus_in_use_o, .control_phase_o);
  scsi_far_end scsi_far_end_i (.clk_sys_i, .dut_data_oe_i(scsi_data_oe_o), .dut_parity_oe_i(scsi_parity_oe_o),
    .dut_busy_oe_i(busy_oe_o), .dut_cd_oe_i(control_data_oe_o), .dut_cd_i(control_data_o),
    .data_n_o(scsi_data_n_i), .parity_n_o(scsi_parity_n_i), .busy_n_o(busy_n_i), .cd_o(control_data_i),
    .strobe_o(data_strobe_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic exp_par(input logic [7:0] v);
    return ~^v;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one host access, held until the read answer is sampled
  task automatic cyc(input logic dma, input logic rd, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    dma_acknowledge_n_i <= ~dma;
    bus_unit_select_n_i <= dma;
    rd_n_i <= ~rd;
    wr_n_i <= rd;
    addr_i <= a;
    host_data_i <= d;
    @(posedge clk_sys_i);
    while (rd && host_data_oe_o !== 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      n++;
    end
    q = host_data_o;
    {dma_acknowledge_n_i, bus_unit_select_n_i, rd_n_i, wr_n_i} <= 4'hf;
    if (n == 8) chk(8'h00, 8'h01);
  endtask
  task automatic rx(input logic [7:0] d, input logic bad, input logic exp, input logic fin);
    scsi_far_end_i.send(d, bad);
    repeat (3) @(posedge clk_sys_i);
    chk(dma_request_o, exp);
    if (exp) begin
      end_of_process_input_n_i <= ~fin;
      cyc(1'b1, 1'b1, ADDR_STATUS, 8'h00);
      end_of_process_input_n_i <= 1'b1;
      chk(q, d);
      chk(dma_request_o, 1'b0);
    end
  endtask
  initial begin
    #2000000;
    err_total++;
    close_out();
  end
  initial begin
    {rst_i, bus_unit_select_n_i, dma_acknowledge_n_i, rd_n_i, wr_n_i, end_of_process_input_n_i} = 6'h3f;
    addr_i = 3'h0;
    host_data_i = 8'h00;
    seed = 32'h0000_b561;
    repeat (12) @(posedge clk_sys_i);
    chk({host_data_oe_o, dma_request_o, parity_error_o, busy_oe_o}, 8'h00);
    rst_i <= 1'b0;
    cyc(1'b0, 1'b0, ADDR_MODE, M_DMA | M_PCK);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      rx(seed[7:0], 1'b0, 1'b1, 1'b0);
    end
    chk(parity_error_o, 1'b0);
    rx(8'h5a, 1'b1, 1'b1, 1'b0);
    chk(parity_error_o, 1'b1);
    cyc(1'b0, 1'b1, ADDR_STATUS, 8'h00);
    chk(q[3], 1'b1);
    chk(parity_error_o, 1'b0);
    cyc(1'b0, 1'b0, ADDR_MODE, M_DMA | M_PCK | M_ARB);
    rx(8'h33, 1'b1, 1'b1, 1'b0);
    chk(parity_error_o, 1'b0);
    cyc(1'b0, 1'b0, ADDR_MODE, M_PCK);
    rx(8'hc4, 1'b0, 1'b0, 1'b0);
    cyc(1'b0, 1'b0, ADDR_MODE, M_DMA);
    rx(8'h81, 1'b0, 1'b1, 1'b1);
    rx(8'h77, 1'b0, 1'b0, 1'b0);
    cyc(1'b0, 1'b1, ADDR_DATA, 8'h00);
    chk(q, 8'h77);
    cyc(1'b0, 1'b0, ADDR_MODE, 8'h00);
    cyc(1'b0, 1'b0, ADDR_MODE, M_DMA | M_SND);
    repeat (3) @(posedge clk_sys_i);
    chk(dma_request_o, 1'b1);
    seed = xs(seed);
    b = seed[7:0] | 8'h01;
    cyc(1'b1, 1'b0, ADDR_DATA, b);
    for (int i = 0; i < 8 && scsi_data_oe_o == 8'h00; i++) @(posedge clk_sys_i);
    chk(scsi_data_oe_o, b);
    chk(scsi_parity_oe_o, exp_par(b));
    cyc(1'b0, 1'b0, ADDR_MODE, 8'h01 << MODE_TGT_BIT);
    cyc(1'b0, 1'b0, ADDR_CTRL, 8'h03);
    repeat (3) @(posedge clk_sys_i);
    chk(bus_in_use_o, 1'b1);
    chk(control_phase_o, 1'b1);
    chk({scsi_parity_n_o, busy_n_o}, 8'h00);
    cyc(1'b0, 1'b1, ADDR_STATUS, 8'h00);
    chk(q, 8'h06);
    cyc(1'b0, 1'b1, ADDR_CTRL, 8'h00);
    chk(q, 8'h03);
    cyc(1'b0, 1'b0, ADDR_MODE, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    chk(control_data_oe_o, 1'b0);
    close_out();
  end
endmodule
